/* pkg/store_fwd_pkg.sv */
// Constants shared by the message store-and-forward buffer
package store_fwd_pkg;
	// ==========================================================
	// Data path
	localparam int       DATA_W     = 8;
	localparam int       ADDR_W     = 12;
	localparam int       A2K_W      = 11;
	localparam int       GRP_W      = 3;
	// Internal characters are ASCII with 1 = mark
	localparam bit [7:0] EOT_CH     = 8'h04;
	localparam bit [7:0] ETX_CH     = 8'h03;
	localparam bit [7:0] FF_CH      = 8'h0C;
	localparam bit [7:0] DEL_CH     = 8'hFF;
	// ==========================================================
	// Memory geometry: two groups of 2000 locations
	localparam bit [10:0] LOCS_LAST  = 11'h07CF;
	localparam bit [11:0] GRP1_BASE  = 12'h07D0;
	localparam bit [11:0] CAP        = 12'h0FA0;
	localparam bit [11:0] CAP_LAST   = 12'h0F9F;
	localparam bit [2:0]  MOD6_LAST  = 3'h5;
	// ==========================================================
	// Clock phases within a four-slot master cycle
	localparam bit [1:0]  PH1_SLOT   = 2'h0;
	localparam bit [1:0]  PH2_SLOT   = 2'h2;
	// ==========================================================
	// Terminator strap codes
	localparam bit [1:0]  SEL_EOT    = 2'h0;
	localparam bit [1:0]  SEL_ETX    = 2'h1;
	localparam bit [1:0]  SEL_FF     = 2'h2;
	// ==========================================================
	// Control states
	typedef enum logic [2:0] {WIPE, IDLE, STORE, HOLD, SEND} state_e;
endpackage : store_fwd_pkg

/* hw/two_entry_buffer.sv */
// Two-entry character buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
	import store_fwd_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire logic              flush,
	input  wire logic              inValid,
	output logic                   inReady,
	input  wire logic [DATA_W-1:0] inData,
	output logic                   outValid,
	input  wire logic              outReady,
	output logic      [DATA_W-1:0] outData
);
	logic [1:0]        cnt_r, cnt_nxt;
	logic [DATA_W-1:0] s0_r, s0_nxt;
	logic [DATA_W-1:0] s1_r, s1_nxt;
	logic              push, pop;

	// ==========================================================
	// Status; no bypass so full stays honest
	assign inReady  = (cnt_r != 2'h2);
	assign outValid = (cnt_r != 2'h0);
	assign outData  = s0_r;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Next slot contents and fill count
	always_comb
	begin
		s0_nxt  = s0_r;
		s1_nxt  = s1_r;
		cnt_nxt = cnt_r;
		if (pop)
		begin
			s0_nxt = s1_r;
		end
		if (push)
		begin
			if ((cnt_r == 2'h0) || ((cnt_r == 2'h1) && pop))
				s0_nxt = inData;
			else
				s1_nxt = inData;
		end
		cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
		if (flush)
			cnt_nxt = 2'h0;
	end

	// Registers
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_r <= 2'h0;
			s0_r  <= 8'h00;
			s1_r  <= 8'h00;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			s0_r  <= s0_nxt;
			s1_r  <= s1_nxt;
		end
	end
endmodule : two_entry_buffer
`default_nettype wire

/* hw/message_store_forward_buffer.sv */
// Store-and-forward message buffer with recirculating memory
// Overview of operation
// - Data leads low mark; control high on
// - Input buffer takes whole characters, two deep
// - Input buffer signals room or full
// - Write modulo six counter picks switch group
// - Keep storing until terminator is stored
// - Reading leaves DELETE in the location
// - Untouched locations recirculate unchanged
// - Eight identical level slices, shared gating
// - Groups lettered; first 2000, then next
// - Each level is a 4000-bit register, two groups of 2000
// - Accept releases message; reject erases it
// - Input blinded while message is sent
// - Hold stored message until a disposition
// - Reject runs a full clearing reset cycle
// - Accept raises the send message request
// - Send until terminator leaves output buffer
// - Output buffer loads, emits, reports state
// - Terminator detected into and out of memory
// - Traffic signal answered by ready confirmation
// - Transfer starts with next character request
// - Read burst stops when full or empty
`timescale 1ns/1ps
`default_nettype none
module message_store_forward_buffer
	import store_fwd_pkg::*;
(
	input  wire logic                           core_clk,
	input  wire logic                           sys_rst,
	input  wire logic                           traffic_pending_in,
	input  wire logic                           accept_message_in,
	input  wire logic                           reject_message_in,
	input  wire logic                           charAvailable,
	input  wire logic [store_fwd_pkg::DATA_W-1:0] dataLeads,
	input  wire logic [1:0]                     endSelect,
	output logic                                accept_capable_out,
	output logic                                receipt_confirm_out,
	output logic                                next_char_request,
	output logic                                send_message_request,
	output logic                                outValid,
	input  wire logic                           outReady,
	output logic      [store_fwd_pkg::DATA_W-1:0] outData
);
	import store_fwd_pkg::*;

	state_e            state_r, state_nxt;
	logic [1:0]        phase_r, phase_nxt;
	logic [1:0]        termSel_r;
	logic [A2K_W-1:0]  wA2k_r, wA2k_nxt, rA2k_r, rA2k_nxt;
	logic [GRP_W-1:0]  wGrp_r, wGrp_nxt, rGrp_r, rGrp_nxt;
	logic [ADDR_W-1:0] count_r, count_nxt, wipeIdx_r, wipeIdx_nxt;
	logic [ADDR_W-1:0] wIdx, rIdx;
	logic [DATA_W-1:0] mem [0:CAP_LAST];
	logic [DATA_W-1:0] leadChar, inChar;
	logic              inPush, inRoom, inHas, wrStb;
	logic              obReady, rdStb, flushBufs, outTerm;

	// ==========================================================
	// Helpers
	function automatic logic isTerm(input logic [DATA_W-1:0] ch, input logic [1:0] sel);
		case (sel)
			SEL_EOT: isTerm = (ch == EOT_CH);
			SEL_ETX: isTerm = (ch == ETX_CH);
			SEL_FF:  isTerm = (ch == FF_CH);
			default: isTerm = 1'b0;
		endcase
	endfunction : isTerm

	// Group from modulo six count, then location within it
	function automatic logic [ADDR_W-1:0] memIdx(input logic [GRP_W-1:0] grp, input logic [A2K_W-1:0] a);
		memIdx = (grp[0] ? GRP1_BASE : 12'h0000) + {1'b0, a};
	endfunction : memIdx

	// ==========================================================
	// Input leads and strap
	// one identical slice per code level
	// lead low means mark, so invert into ASCII
	genvar g;
	generate
		for (g = 0; g < DATA_W; g++)
		begin : levelGen
			assign leadChar[g] = ~dataLeads[g];
		end
	endgenerate

	// strap sampled by the clock, never by reset
	always_ff @(posedge core_clk)
	begin
		termSel_r <= endSelect;
	end

	// ==========================================================
	// Character buffers
	// a full input buffer withdraws the request
	// request only while storing and room remains
	assign next_char_request = (state_r == STORE) && inRoom;
	assign inPush    = charAvailable && next_char_request;
	assign flushBufs = (state_r == WIPE);

	two_entry_buffer inBuf (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.flush    (flushBufs),
		.inValid  (inPush),
		.inReady  (inRoom),
		.inData   (leadChar),
		.outValid (inHas),
		.outReady (wrStb),
		.outData  (inChar)
	);

	// output side, reports room back to memory reads
	two_entry_buffer outBuf (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.flush    (flushBufs),
		.inValid  (rdStb),
		.inReady  (obReady),
		.inData   (mem[rIdx]),
		.outValid (outValid),
		.outReady (outReady),
		.outData  (outData)
	);

	// ==========================================================
	// Memory strobes
	assign wIdx = memIdx(wGrp_r, wA2k_r);
	assign rIdx = memIdx(rGrp_r, rA2k_r);
	// writes on phase 1, reads on phase 2
	// keep storing while a character waits and room exists
	assign wrStb = (state_r == STORE) && (phase_r == PH1_SLOT) && inHas && (count_r != CAP);
	// burst stops on full output buffer or empty memory
	assign rdStb = (state_r == SEND) && (phase_r == PH2_SLOT) && obReady && (count_r != 12'h0000);
	// end seen as it leaves the last stage
	assign outTerm = outValid && outReady && isTerm(outData, termSel_r);

	// Recirculating store; array holds no reset, wipe clears it
	always_ff @(posedge core_clk)
	begin
		if (state_r == WIPE)
			mem[wipeIdx_r] <= DEL_CH;
		else if (wrStb)
			mem[wIdx] <= inChar;
		else if (rdStb)
			mem[rIdx] <= DEL_CH;
		// all other locations keep their contents
	end

	// ==========================================================
	// Counters and control
	always_comb
	begin
		state_nxt   = state_r;
		phase_nxt   = 2'(phase_r + 2'h1);
		wA2k_nxt    = wA2k_r;
		wGrp_nxt    = wGrp_r;
		rA2k_nxt    = rA2k_r;
		rGrp_nxt    = rGrp_r;
		count_nxt   = count_r;
		wipeIdx_nxt = wipeIdx_r;
		// 2000 locations per group; group step
		if (wrStb)
		begin
			wA2k_nxt = (wA2k_r == LOCS_LAST) ? 11'h000 : 11'(wA2k_r + 11'h001);
			if (wA2k_r == LOCS_LAST)
				wGrp_nxt = (wGrp_r == MOD6_LAST) ? 3'h0 : 3'(wGrp_r + 3'h1);
		end
		if (rdStb)
		begin
			rA2k_nxt = (rA2k_r == LOCS_LAST) ? 11'h000 : 11'(rA2k_r + 11'h001);
			if (rA2k_r == LOCS_LAST)
				rGrp_nxt = (rGrp_r == MOD6_LAST) ? 3'h0 : 3'(rGrp_r + 3'h1);
		end
		count_nxt = 12'(count_r + {11'h000, wrStb} - {11'h000, rdStb});
		unique case (state_r)
			WIPE:
			begin
				wipeIdx_nxt = 12'(wipeIdx_r + 12'h001);
				if (wipeIdx_r == CAP_LAST)
				begin
					state_nxt   = IDLE;
					wipeIdx_nxt = 12'h0000;
					wA2k_nxt    = 11'h000;
					rA2k_nxt    = 11'h000;
					wGrp_nxt    = 3'h0;
					rGrp_nxt    = 3'h0;
					count_nxt   = 12'h0000;
				end
			end
			// traffic moves to storing, confirmed by ready
			IDLE:
				if (traffic_pending_in)
					state_nxt = STORE;
			// terminator checked on the way in
			STORE:
				if (wrStb && isTerm(inChar, termSel_r))
					state_nxt = HOLD;
			HOLD:
				if (reject_message_in)
					state_nxt = WIPE;
				else if (accept_message_in)
					state_nxt = SEND;
			// input stays blind until sending ends
			SEND:
				if (outTerm)
					state_nxt = IDLE;
		endcase
	end

	// Reset starts with a clearing sweep of memory
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r   <= WIPE;
			phase_r   <= 2'h0;
			wA2k_r    <= 11'h000;
			rA2k_r    <= 11'h000;
			wGrp_r    <= 3'h0;
			rGrp_r    <= 3'h0;
			count_r   <= 12'h0000;
			wipeIdx_r <= 12'h0000;
		end
		else
		begin
			state_r   <= state_nxt;
			phase_r   <= phase_nxt;
			wA2k_r    <= wA2k_nxt;
			rA2k_r    <= rA2k_nxt;
			wGrp_r    <= wGrp_nxt;
			rGrp_r    <= rGrp_nxt;
			count_r   <= count_nxt;
			wipeIdx_r <= wipeIdx_nxt;
		end
	end

	// ==========================================================
	// Message control leads
	assign accept_capable_out   = (state_r == IDLE);
	assign receipt_confirm_out  = (state_r == STORE);
	assign send_message_request = (state_r == SEND);

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	confirm_on_traffic_a: assert property (
		(state_r == IDLE) && traffic_pending_in |=> receipt_confirm_out && !accept_capable_out)
		else $error("traffic not confirmed");
	full_refuses_a: assert property (
		(inPush && !wrStb) ##1 (inPush && !wrStb) |=> !next_char_request && !inRoom)
		else $error("request while input full");
	blind_send_a: assert property (
		send_message_request |-> !next_char_request && !accept_capable_out && !wrStb)
		else $error("input open during send");
	hold_waits_a: assert property (
		(state_r == HOLD) && !accept_message_in && !reject_message_in |=> (state_r == HOLD) && !rdStb)
		else $error("held message moved");
	reject_wipes_a: assert property (
		(state_r == HOLD) && reject_message_in |=> (state_r == WIPE) && (wipeIdx_r == 12'h0000))
		else $error("reject did not clear");
	accept_sends_a: assert property (
		(state_r == HOLD) && accept_message_in && !reject_message_in |=> send_message_request)
		else $error("accept did not send");
	term_stored_a: assert property (
		wrStb && isTerm(inChar, termSel_r) |=> (state_r == HOLD) && (mem[$past(wIdx)] == $past(inChar)))
		else $error("terminator not held");
	read_erases_a: assert property (
		rdStb |=> mem[$past(rIdx)] == DEL_CH)
		else $error("read not destructive");
	phase_split_a: assert property (
		(wrStb |-> phase_r == PH1_SLOT) and (rdStb |-> ##2 phase_r == PH1_SLOT))
		else $error("shift on wrong phase");
	burst_stop_a: assert property (
		rdStb |-> obReady && (count_r != 12'h0000))
		else $error("read past full or empty");
	send_end_a: assert property (
		send_message_request && outTerm |=> accept_capable_out)
		else $error("send did not end");
	group_range_a: assert property (
		(wGrp_r <= MOD6_LAST) && (wA2k_r <= LOCS_LAST) && (rA2k_r <= LOCS_LAST))
		else $error("counter out of range");
	recirc_keep_a: assert property (
		!wrStb && !rdStb && (state_r != WIPE) |=> $stable(mem[0]))
		else $error("idle location changed");

	store_to_hold_c: cover property ((state_r == STORE) ##1 (state_r == HOLD));
	reject_path_c:   cover property ((state_r == HOLD) ##1 (state_r == WIPE));
	send_done_c:     cover property (send_message_request ##1 accept_capable_out);
	out_stall_c:     cover property (outValid && !outReady && !obReady);
	in_full_c:       cover property ((state_r == STORE) && inHas && !inRoom);
endmodule : message_store_forward_buffer
`default_nettype wire

/* test/station_controller_model.sv */
// Behavioural station controller driving the parallel terminal link
`timescale 1ns/1ps
`default_nettype none
module station_controller_model
	import store_fwd_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       startMsg,
	input  wire logic [7:0] msgLen,
	input  wire logic [7:0] termChar,
	input  wire logic       dispAccept,
	input  wire logic       slow,
	input  wire logic       accept_capable_out,
	input  wire logic       receipt_confirm_out,
	input  wire logic       next_char_request,
	output logic            traffic_pending_in,
	output logic            charAvailable,
	output logic      [7:0] dataLeads,
	output logic            accept_message_in,
	output logic            reject_message_in,
	output logic            msgDone
);
	int phase;
	int idx;
	int gap;
	// Character 1 is the terminator XOR 07h: EOT and ETX swap, FF gives 0Bh
	function automatic logic [7:0] msgChar(input int i);
		if (i == int'(msgLen) - 1)
			return termChar;
		if (i == 1)
			return termChar ^ 8'h07;
		return 8'h41 + 8'(i);
	endfunction : msgChar
	// ==========================================================
	// Controller sequence
	always_ff @(posedge core_clk or posedge sys_rst)
		if (sys_rst)
		begin
			phase <= 0; idx <= 0; gap <= 0; traffic_pending_in <= 1'b0; charAvailable <= 1'b0;
			dataLeads <= 8'h55; accept_message_in <= 1'b0; reject_message_in <= 1'b0; msgDone <= 1'b0;
		end
		else
		begin
			accept_message_in <= 1'b0;
			reject_message_in <= 1'b0;
			// Idle leads keep toggling so a stale word is never mistaken for data
			if (!charAvailable)
				dataLeads <= ~dataLeads;
			case (phase)
				0: if (startMsg && accept_capable_out)
				begin
					traffic_pending_in <= 1'b1; idx <= 0; msgDone <= 1'b0; phase <= 1;
				end
				1: if (receipt_confirm_out)
				begin
					traffic_pending_in <= 1'b0; phase <= 2;
				end
				2: if (charAvailable && next_char_request)
				begin
					idx <= idx + 1;
					gap <= slow ? 3 : 0;
					charAvailable <= !slow && idx + 1 < int'(msgLen);
					dataLeads <= ~msgChar(idx + 1);
					if (idx + 1 == int'(msgLen))
						phase <= 3;
				end
				else if (!charAvailable && gap == 0 && next_char_request)
				begin
					charAvailable <= 1'b1; dataLeads <= ~msgChar(idx);
				end
				else if (gap != 0)
					gap <= gap - 1;
				3: if (!receipt_confirm_out)
				begin
					gap <= slow ? 20 : 0; phase <= 4;
				end
				4: if (gap == 0)
				begin
					accept_message_in <= dispAccept; reject_message_in <= !dispAccept; msgDone <= 1'b1; phase <= 5;
				end
				else
					gap <= gap - 1;
				default: if (!startMsg)
					phase <= 0;
			endcase
		end
endmodule : station_controller_model
`default_nettype wire

/* test/message_store_forward_buffer_test.sv */
// Self-checking testbench for the message store-and-forward buffer
`timescale 1ns/1ps
`default_nettype none
module message_store_forward_buffer_test;
	import store_fwd_pkg::*;
	logic       core_clk, sys_rst, traffic_pending_in, accept_message_in, reject_message_in, charAvailable;
	logic [7:0] dataLeads, outData, lenR, termR;
	logic [1:0] endSelect;
	logic       accept_capable_out, receipt_confirm_out, next_char_request, send_message_request;
	logic       outValid, outReady, startMsg, dispAccept, slowR, msgDone;
	int         rxIdx, cycles, errors, checks;
	message_store_forward_buffer u_message_store_forward_buffer (.core_clk, .sys_rst, .traffic_pending_in,
		.accept_message_in, .reject_message_in, .charAvailable, .dataLeads, .endSelect, .accept_capable_out,
		.receipt_confirm_out, .next_char_request, .send_message_request, .outValid, .outReady, .outData);
	station_controller_model u_station_controller_model (.core_clk, .sys_rst, .startMsg, .msgLen(lenR),
		.termChar(termR), .dispAccept, .slow(slowR), .accept_capable_out, .receipt_confirm_out,
		.next_char_request, .traffic_pending_in, .charAvailable, .dataLeads, .accept_message_in,
		.reject_message_in, .msgDone);
	// Clock and cycle ceiling
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			test_done;
		end
	end
	// Receiver stalls seven of eight cycles in slow runs to fill the buffer
	always @(posedge core_clk)
		outReady <= !slowR || cycles % 8 == 0;
	function automatic logic [7:0] expChar(input int i);
		if (i == int'(lenR) - 1)
			return termR;
		if (i == 1)
			return termR ^ 8'h07;
		return 8'h41 + 8'(i);
	endfunction : expChar
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic checkBit(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask : checkBit
	// Output monitor
	always @(posedge core_clk)
		if (!sys_rst)
		begin
			checkBit(outValid & ~send_message_request, 1'b0);
			checkBit(next_char_request & ~receipt_confirm_out, 1'b0);
			if (outValid && outReady)
			begin
				check8(outData, expChar(rxIdx));
				checkBit(receipt_confirm_out, 1'b0);
				rxIdx++;
			end
		end
	// One message through the link, then the disposition
	task automatic runMsg(input logic [1:0] sel, input logic [7:0] term, input logic [7:0] len, input logic acc,
		input logic slw);
		int n;
		@(posedge core_clk);
		endSelect <= sel; termR <= term; lenR <= len; dispAccept <= acc; slowR <= slw; startMsg <= 1'b1;
		rxIdx = 0;
		n = 0;
		// Done flag of the previous message clears only when this one starts
		while (msgDone && n < 6000)
		begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		while (!msgDone && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		startMsg <= 1'b0;
		n = 0;
		while (!accept_capable_out && n < 6000)
		begin
			@(posedge core_clk);
			n++;
		end
		checkBit(accept_capable_out, 1'b1);
		if (acc)
			check8(8'(rxIdx), len);
		else
		begin
			check8(8'(rxIdx), 8'h00);
			checkBit(n > 3990, 1'b1);
		end
	endtask : runMsg
	task automatic test_sweep;
		int n;
		n = 0;
		while (!accept_capable_out && n < 4100)
		begin
			@(posedge core_clk);
			n++;
		end
		checkBit(accept_capable_out, 1'b1);
		checkBit(n > 3990, 1'b1);
	endtask : test_sweep
	task automatic test_accept_eot;
		runMsg(SEL_EOT, EOT_CH, 8'h0C, 1'b1, 1'b0);
	endtask : test_accept_eot
	task automatic test_accept_etx_stall;
		runMsg(SEL_ETX, ETX_CH, 8'h09, 1'b1, 1'b1);
	endtask : test_accept_etx_stall
	task automatic test_reject_ff;
		runMsg(SEL_FF, FF_CH, 8'h06, 1'b0, 1'b0);
	endtask : test_reject_ff
	task automatic test_short_after_reject;
		runMsg(SEL_FF, FF_CH, 8'h03, 1'b1, 1'b0);
	endtask : test_short_after_reject
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// Main sequence
	initial
	begin
		core_clk = 1'b0; sys_rst = 1'b1; startMsg = 1'b0; endSelect = 2'h0; lenR = 8'h04; termR = EOT_CH;
		dispAccept = 1'b1; slowR = 1'b0; outReady = 1'b0; rxIdx = 0; cycles = 0; errors = 0; checks = 0;
		repeat (3) @(posedge core_clk);
		#1;
		checkBit(accept_capable_out | receipt_confirm_out | send_message_request | outValid, 1'b0);
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		test_sweep;
		test_accept_eot;
		test_accept_etx_stall;
		test_reject_ff;
		test_short_after_reject;
		test_done;
	end
endmodule : message_store_forward_buffer_test
`default_nettype wire
